// file: common/qsr_map.svh
// Constants of the fault status reporting block: widths, limits and reset values
`ifndef QSR_MAP_SVH
`define QSR_MAP_SVH

`define QSR_REG_W 16
`define QSR_COND_W 9
`define QSR_OP_ENABLE_W 8
`define QSR_ZERO 16'h0000
`define QSR_COND_ZERO 9'h000
`define QSR_UNUSED_ZERO 7'h00
`define QSR_OP_ENABLE_MAX 16'h00ff
`define QSR_RISE_MAX 16'h01ff
`define QSR_ENABLE_RESET 16'h0000
`define QSR_FALL_RESET 16'h0000
`define QSR_RISE_RESET 16'h01ff

`endif

// file: common/qsr_pkg.sv
// Types of the fault status reporting block
package qsr_pkg;

  // Fault lines in condition bit order, bit 8 first
  typedef struct packed {
    logic output_overvoltage_fault;
    logic line_input_fault;
    logic overcurrent_fault;
    logic fan_fault;
    logic output_short_fault;
    logic overtemperature_fault;
    logic overpower_fault;
    logic inner_dc_stage_fault;
    logic inner_ac_stage_fault;
  } qsr_fault_t;

  typedef enum logic [3:0] {
    QSR_CMD_OP_EVENT_Q,
    QSR_CMD_OP_ENABLE_W,
    QSR_CMD_OP_ENABLE_Q,
    QSR_CMD_COND_Q,
    QSR_CMD_EVENT_Q,
    QSR_CMD_ENABLE_W,
    QSR_CMD_ENABLE_Q,
    QSR_CMD_FALL_W,
    QSR_CMD_FALL_Q,
    QSR_CMD_RISE_W,
    QSR_CMD_RISE_Q,
    QSR_CMD_ERROR_Q
  } qsr_cmd_t;

  typedef enum logic [2:0] {
    QSR_ERR_NONE,
    QSR_ERR_FORMAT,
    QSR_ERR_RANGE,
    QSR_ERR_TOO_MANY,
    QSR_ERR_EXEC
  } qsr_err_t;

  typedef struct packed {
    logic valid;
    qsr_cmd_t code;
    logic [15:0] data;
  } qsr_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
    qsr_err_t error;
  } qsr_rsp_t;

  typedef struct packed {
    logic valid;
    qsr_err_t code;
  } qsr_err_report_t;

endpackage

// file: logic/qsr_sync.sv
// Two-stage synchroniser for the asynchronous fault lines
`timescale 1ns/10ps
`include "qsr_map.svh"

module qsr_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Lines
  input wire logic [`QSR_COND_W-1:0] async_in,
  output logic [`QSR_COND_W-1:0] sync_out
);

  logic [`QSR_COND_W-1:0] stage1;
  logic [`QSR_COND_W-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < `QSR_COND_W; i = i + 1) begin : g_bit
      always_ff @(posedge clock) begin
        if (srst) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;

endmodule

// file: logic/qsr_core.sv
// Fault status reporting block: condition, edge filters, event, masks, error query
`timescale 1ns/10ps
`include "qsr_map.svh"

module qsr_core (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Fault lines from the power stages, asynchronous
  input wire qsr_pkg::qsr_fault_t fault_pins,
  // Decoded status commands from the command parser
  input wire qsr_pkg::qsr_req_t req,
  output qsr_pkg::qsr_rsp_t rsp,
  // Parser error reports
  input wire qsr_pkg::qsr_err_report_t err_report,
  // Status byte link
  input wire logic service_fault_enable,
  output logic fault_summary_bit
);

  import qsr_pkg::*;

  // Synchronised condition lines
  logic [`QSR_COND_W-1:0] cond_sync;
  logic [`QSR_REG_W-1:0] fault_condition;

  qsr_sync u_sync (
    .clock(clock),
    .srst(srst),
    .async_in(fault_pins),
    .sync_out(cond_sync)
  );

  // Only the second synchroniser stage feeds the condition word, never the first

  // Decoded command strobes
  logic wr_enable;
  logic wr_fall;
  logic wr_rise;
  logic wr_op_enable;
  logic rd_event;
  logic rd_error;
  logic rise_in_range;
  logic op_in_range;
  logic range_fault;

  always_comb begin
    wr_enable = 1'b0;
    wr_fall = 1'b0;
    wr_rise = 1'b0;
    wr_op_enable = 1'b0;
    rd_event = 1'b0;
    rd_error = 1'b0;
    if (req.valid) begin
      case (req.code)
        QSR_CMD_ENABLE_W: begin
          wr_enable = 1'b1;
        end
        QSR_CMD_FALL_W: begin
          wr_fall = 1'b1;
        end
        QSR_CMD_RISE_W: begin
          wr_rise = 1'b1;
        end
        QSR_CMD_OP_ENABLE_W: begin
          wr_op_enable = 1'b1;
        end
        QSR_CMD_EVENT_Q: begin
          rd_event = 1'b1;
        end
        QSR_CMD_ERROR_Q: begin
          rd_error = 1'b1;
        end
        default: begin
          // Other queries only read state, so they need no strobe
          rd_event = 1'b0;
        end
      endcase
    end
    rise_in_range = (req.data <= `QSR_RISE_MAX);
    op_in_range = (req.data <= `QSR_OP_ENABLE_MAX);
    // Out of range values are refused and logged as a range error
    range_fault = (wr_rise && !rise_in_range) || (wr_op_enable && !op_in_range);
  end

  // Mask and filter registers
  logic [`QSR_REG_W-1:0] fault_enable_mask;
  logic [`QSR_REG_W-1:0] falling_edge_filter;
  logic [`QSR_REG_W-1:0] rising_edge_filter;
  logic [`QSR_REG_W-1:0] next_fault_enable_mask;
  logic [`QSR_REG_W-1:0] next_falling_edge_filter;
  logic [`QSR_REG_W-1:0] next_rising_edge_filter;

  always_comb begin
    next_fault_enable_mask = fault_enable_mask;
    next_falling_edge_filter = falling_edge_filter;
    next_rising_edge_filter = rising_edge_filter;
    if (wr_enable) begin
      next_fault_enable_mask = req.data;
    end
    if (wr_fall) begin
      next_falling_edge_filter = req.data;
    end
    // A refused rising filter write leaves the old filter in place
    if (wr_rise && rise_in_range) begin
      next_rising_edge_filter = req.data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fault_enable_mask <= `QSR_ENABLE_RESET;
      falling_edge_filter <= `QSR_FALL_RESET;
      rising_edge_filter <= `QSR_RISE_RESET;
    end else begin
      fault_enable_mask <= next_fault_enable_mask;
      falling_edge_filter <= next_falling_edge_filter;
      rising_edge_filter <= next_rising_edge_filter;
    end
  end

  // Edge detection and event latching
  logic [`QSR_REG_W-1:0] prev_condition;
  logic [`QSR_REG_W-1:0] fault_event;
  logic [`QSR_REG_W-1:0] next_prev_condition;
  logic [`QSR_REG_W-1:0] next_fault_event;
  logic [`QSR_REG_W-1:0] rise_edges;
  logic [`QSR_REG_W-1:0] fall_edges;
  logic [`QSR_REG_W-1:0] passed_edges;
  logic [`QSR_REG_W-1:0] enabled_events;

  genvar b;
  generate
    for (b = 0; b < `QSR_REG_W; b = b + 1) begin : g_bit
      if (b < `QSR_COND_W) begin : g_line
        assign fault_condition[b] = cond_sync[b];
      end else begin : g_spare
        // No fault line sits behind these bits, so they can never raise an event
        assign fault_condition[b] = 1'b0;
      end
      always_comb begin
        rise_edges[b] = fault_condition[b] & ~prev_condition[b] & rising_edge_filter[b];
        fall_edges[b] = ~fault_condition[b] & prev_condition[b] & falling_edge_filter[b];
        // A bit clear in both filters contributes to neither term
        passed_edges[b] = rise_edges[b] | fall_edges[b];
        next_prev_condition[b] = fault_condition[b];
        // Edges arriving with the read survive it, so nothing is lost
        if (rd_event) begin
          next_fault_event[b] = passed_edges[b];
        end else begin
          next_fault_event[b] = fault_event[b] | passed_edges[b];
        end
        enabled_events[b] = next_fault_event[b] & fault_enable_mask[b];
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (srst) begin
      prev_condition <= `QSR_ZERO;
      fault_event <= `QSR_ZERO;
    end else begin
      prev_condition <= next_prev_condition;
      fault_event <= next_fault_event;
    end
  end

  // Summary bit toward the status byte
  logic next_fault_summary_bit;

  always_comb begin
    // Taken from the next event value so the bit moves in step with the event register
    next_fault_summary_bit = service_fault_enable && (enabled_events != `QSR_ZERO);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fault_summary_bit <= 1'b0;
    end else begin
      fault_summary_bit <= next_fault_summary_bit;
    end
  end

  // Parser error slot: one pending error; a second before the query overflows
  qsr_err_t pending_error;
  qsr_err_t next_pending_error;
  logic new_error;
  logic two_errors;
  qsr_err_t incoming;

  always_comb begin
    new_error = (err_report.valid && (err_report.code != QSR_ERR_NONE)) || range_fault;
    two_errors = err_report.valid && (err_report.code != QSR_ERR_NONE) && range_fault;
    if (range_fault) begin
      incoming = QSR_ERR_RANGE;
    end else begin
      incoming = err_report.code;
    end
    next_pending_error = pending_error;
    case ({rd_error, new_error})
      2'b01: begin
        if (two_errors || (pending_error != QSR_ERR_NONE)) begin
          next_pending_error = QSR_ERR_TOO_MANY;
        end else begin
          next_pending_error = incoming;
        end
      end
      2'b10: begin
        next_pending_error = QSR_ERR_NONE;
      end
      2'b11: begin
        // A new error in the query cycle is kept for the next query
        if (two_errors) begin
          next_pending_error = QSR_ERR_TOO_MANY;
        end else begin
          next_pending_error = incoming;
        end
      end
      default: begin
        next_pending_error = pending_error;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pending_error <= QSR_ERR_NONE;
    end else begin
      pending_error <= next_pending_error;
    end
  end

  // Response register: one answer per request, one cycle later
  qsr_rsp_t next_rsp;

  always_comb begin
    next_rsp.valid = req.valid;
    next_rsp.data = `QSR_ZERO;
    next_rsp.error = QSR_ERR_NONE;
    if (req.valid) begin
      case (req.code)
        QSR_CMD_OP_EVENT_Q: begin
          next_rsp.data = `QSR_ZERO;
        end
        QSR_CMD_ENABLE_W, QSR_CMD_FALL_W, QSR_CMD_RISE_W, QSR_CMD_OP_ENABLE_W: begin
          // Writes are acknowledged with a zero word
          next_rsp.data = `QSR_ZERO;
        end
        QSR_CMD_OP_ENABLE_Q: begin
          next_rsp.data = `QSR_ZERO;
        end
        QSR_CMD_COND_Q: begin
          next_rsp.data = fault_condition;
        end
        QSR_CMD_EVENT_Q: begin
          next_rsp.data = fault_event;
        end
        QSR_CMD_ENABLE_Q: begin
          next_rsp.data = fault_enable_mask;
        end
        QSR_CMD_FALL_Q: begin
          next_rsp.data = falling_edge_filter;
        end
        QSR_CMD_RISE_Q: begin
          next_rsp.data = rising_edge_filter;
        end
        QSR_CMD_ERROR_Q: begin
          next_rsp.error = pending_error;
        end
        default: begin
          next_rsp.data = `QSR_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rsp.valid <= 1'b0;
      rsp.data <= `QSR_ZERO;
      rsp.error <= QSR_ERR_NONE;
    end else begin
      rsp <= next_rsp;
    end
  end

endmodule

// file: sim/qsr_core_sva.sv
// Port checker of the fault status reporting block
`timescale 1ns/10ps
module qsr_core_sva
  import qsr_pkg::*;
(
  // Clock and reset
  input logic clock,
  input logic srst,
  // Watched ports
  input qsr_fault_t fault_pins,
  input qsr_req_t req,
  input qsr_rsp_t rsp,
  input qsr_err_report_t err_report,
  input logic service_fault_enable,
  input logic fault_summary_bit
);
  wire v = req.valid;
  wire qsr_cmd_t c = req.code;
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  a_op_event_zero: assert property (v && c == QSR_CMD_OP_EVENT_Q |=> rsp.data == 16'h0000)
    else $error("op event not zero");
  a_op_mask_zero: assert property (v && c == QSR_CMD_OP_ENABLE_Q |=> rsp.data == 16'h0000)
    else $error("op mask not zero");
  // Four quiet cycles cover the two synchroniser stages with margin
  a_cond_live: assert property ($stable(fault_pins)[*4] ##0 v && c == QSR_CMD_COND_Q
    |=> rsp.data == {7'h00, $past(fault_pins)}) else $error("condition not live");
  a_event_width: assert property (v && c == QSR_CMD_EVENT_Q |=> rsp.data[15:9] == 7'h00)
    else $error("event high bits set");
  a_summary_off: assert property (!service_fault_enable |=> !fault_summary_bit)
    else $error("summary without enable");
  a_every_answer: assert property (v |=> rsp.valid)
    else $error("no answer");
  a_idle_quiet: assert property (!v |=> !rsp.valid && rsp.data == 16'h0000)
    else $error("answer without request");
  a_err_no_data: assert property (v && c == QSR_CMD_ERROR_Q |=> rsp.data == 16'h0000)
    else $error("error query data");
  cover property (fault_summary_bit);
  cover property (rsp.valid && rsp.error == QSR_ERR_TOO_MANY);
  cover property (err_report.valid);
endmodule
bind qsr_core qsr_core_sva chk (
  .clock(clock),
  .srst(srst),
  .fault_pins(fault_pins),
  .req(req),
  .rsp(rsp),
  .err_report(err_report),
  .service_fault_enable(service_fault_enable),
  .fault_summary_bit(fault_summary_bit)
);

// file: sim/qsr_host_model.sv
// Host controller model issuing status commands
`timescale 1ns/10ps
module qsr_host_model
  import qsr_pkg::*;
(
  // Clock
  input logic clock,
  // Command link
  output qsr_req_t req,
  input qsr_rsp_t rsp
);
  initial req = '0;
  task automatic cmd(input qsr_cmd_t c, input logic [15:0] d, output logic [15:0] q,
    output qsr_err_t e);
    @(posedge clock);
    req <= '{1'b1, c, d};
    @(posedge clock);
    // Released data is inverted so a stale word cannot pass as held
    req <= '{1'b0, QSR_CMD_ERROR_Q, ~d};
    #1;
    q = rsp.data;
    e = rsp.error;
  endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench of the fault status reporting block
`timescale 1ns/10ps
module testbench;
  import qsr_pkg::*;
  logic clock, srst, sfe, fsb;
  qsr_fault_t pins;
  qsr_req_t req;
  qsr_rsp_t rsp;
  qsr_err_report_t erp;
  logic [15:0] q;
  qsr_err_t e;
  int n_errors, num_checks;
  qsr_core uut (.clock(clock), .srst(srst), .fault_pins(pins), .req(req), .rsp(rsp),
    .err_report(erp), .service_fault_enable(sfe), .fault_summary_bit(fsb));
  qsr_host_model host (.clock(clock), .req(req), .rsp(rsp));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input qsr_cmd_t c, input logic [15:0] x);
    host.cmd(c, 16'h0000, q, e);
    check(q, x);
  endtask
  task wr(input qsr_cmd_t c, input logic [15:0] d);
    host.cmd(c, d, q, e);
  endtask
  task rde(input qsr_err_t x);
    host.cmd(QSR_CMD_ERROR_Q, 16'h0000, q, e);
    check({13'h0000, e}, {13'h0000, x});
  endtask
  // Six edges cover synchroniser, event latch and summary register
  task fault(input logic [8:0] p);
    @(posedge clock);
    pins <= p;
    repeat (6) @(posedge clock);
    #1;
  endtask
  task t_reset_regs;
    rd(QSR_CMD_ENABLE_Q, 16'h0000);
    rd(QSR_CMD_FALL_Q, 16'h0000);
    rd(QSR_CMD_RISE_Q, 16'h01ff);
    rd(QSR_CMD_OP_EVENT_Q, 16'h0000);
    rd(QSR_CMD_EVENT_Q, 16'h0000);
  endtask
  task t_write_ranges;
    wr(QSR_CMD_ENABLE_W, 16'hffff);
    rd(QSR_CMD_ENABLE_Q, 16'hffff);
    wr(QSR_CMD_FALL_W, 16'hffff);
    rd(QSR_CMD_FALL_Q, 16'hffff);
    wr(QSR_CMD_RISE_W, 16'h00a5);
    wr(QSR_CMD_RISE_W, 16'h0200);
    rd(QSR_CMD_RISE_Q, 16'h00a5);
    rde(QSR_ERR_RANGE);
    wr(QSR_CMD_OP_ENABLE_W, 16'h00ff);
    rd(QSR_CMD_OP_ENABLE_Q, 16'h0000);
    rde(QSR_ERR_NONE);
    wr(QSR_CMD_OP_ENABLE_W, 16'h0100);
    rde(QSR_ERR_RANGE);
  endtask
  task t_edges;
    wr(QSR_CMD_RISE_W, 16'h00aa);
    wr(QSR_CMD_FALL_W, 16'h0155);
    fault(9'h1c3);
    rd(QSR_CMD_COND_Q, 16'h01c3);
    rd(QSR_CMD_OP_EVENT_Q, 16'h0000);
    rd(QSR_CMD_EVENT_Q, 16'h0082);
    rd(QSR_CMD_EVENT_Q, 16'h0000);
    fault(9'h000);
    rd(QSR_CMD_EVENT_Q, 16'h0141);
    wr(QSR_CMD_RISE_W, 16'h0000);
    wr(QSR_CMD_FALL_W, 16'hfe00);
    fault(9'h1ff);
    fault(9'h000);
    rd(QSR_CMD_EVENT_Q, 16'h0000);
  endtask
  task t_summary;
    wr(QSR_CMD_RISE_W, 16'h01ff);
    wr(QSR_CMD_ENABLE_W, 16'h0004);
    @(posedge clock);
    sfe <= 1'b1;
    fault(9'h008);
    check({15'h0000, fsb}, 16'h0000);
    fault(9'h00c);
    check({15'h0000, fsb}, 16'h0001);
    @(posedge clock);
    sfe <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check({15'h0000, fsb}, 16'h0000);
    rd(QSR_CMD_EVENT_Q, 16'h000c);
  endtask
  task t_errors;
    for (int i = 1; i < 5; i++) begin
      @(posedge clock);
      erp <= '{1'b1, qsr_err_t'(i)};
      @(posedge clock);
      erp <= '{1'b0, QSR_ERR_NONE};
      rde(qsr_err_t'(i));
    end
    @(posedge clock);
    erp <= '{1'b1, QSR_ERR_FORMAT};
    @(posedge clock);
    erp <= '{1'b1, QSR_ERR_EXEC};
    @(posedge clock);
    erp <= '{1'b0, QSR_ERR_NONE};
    rde(QSR_ERR_TOO_MANY);
    // A parser error and a refused write in the same cycle overflow the slot
    fork
      host.cmd(QSR_CMD_RISE_W, 16'h0200, q, e);
      begin
        @(posedge clock);
        erp <= '{1'b1, QSR_ERR_FORMAT};
        @(posedge clock);
        erp <= '{1'b0, QSR_ERR_NONE};
      end
    join
    rde(QSR_ERR_TOO_MANY);
  endtask
  task results;
    $display("Mismatches %0d, comparisons %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    sfe = 1'b0;
    pins = '0;
    erp = '0;
    n_errors = 0;
    num_checks = 0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    t_reset_regs;
    t_write_ranges;
    t_edges;
    t_summary;
    t_errors;
    results;
  end
  initial begin
    repeat (3000) @(posedge clock);
    n_errors++;
    results;
  end
endmodule
